// ===== logic/lcddr_ctrl_regs.sv
/*
  Drawing and display control register bank: colour, fill/line launch,
  scroll origin, area selection and image-transfer transparency.
  Write-only: there is no read path, so software must keep its own copy.
  Assumes a drawing engine outside that takes one-cycle start pulses, reports
  busy, and reports done after its last pixel write has been committed, and a
  display timing generator that marks each frame start.
*/

`timescale 1ns/100ps
`include "lcddr_defines.svh"
module lcddr_ctrl_regs #(
    parameter int unsigned DONE_CYCLES = `LCDDR_DONE_PULSE_CYC,
    parameter int unsigned DONE_CW = 8
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,

    // Host bus
    input wire logic [`LCDDR_ADDR_W-1:0] bus_addr_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_be_hi_i,
    input wire logic bus_be_lo_i,

    // Colour depth
    input wire lcddr_pkg::lcddr_colour_mode_e colour_mode_i,

    // Drawing engine
    input wire logic engine_busy_i,
    input wire logic rect_done_i,
    input wire logic line_done_i,

    // Display timing
    input wire logic frame_start_i,

    // Image stream
    input wire logic img_xfer_i,
    input wire logic img_pix_valid_i,
    input wire lcddr_pkg::lcddr_colour_t img_pix_i,

    // Drawing colour
    output lcddr_pkg::lcddr_colour_t draw_colour_o,
    output logic [4:0] red_field_o,
    output logic [5:0] green_field_o,
    output logic [4:0] blue_field_o,
    output logic [1:0] palette_mode_field_o,
    output logic [5:0] palette_index_field_o,

    // Start pulses
    output logic rect_start_o,
    output logic line_start_o,

    // Scroll origin
    output logic [`LCDDR_VIEW_COL_W-1:0] view_col_o,
    output logic [`LCDDR_VIEW_ROW_W-1:0] view_row_o,

    // Area selects
    output lcddr_pkg::lcddr_area_t shown_area_o,
    output lcddr_pkg::lcddr_area_t target_area_o,

    // Filtered pixels
    output logic img_pix_we_o,
    output lcddr_pkg::lcddr_colour_t img_pix_o,

    // Completion, active low
    output logic done_pulse_out_n_o
);
    import lcddr_pkg::*;

    // Byte addresses of the registers
    localparam logic [`LCDDR_ADDR_W-1:0] A_COLOUR = `LCDDR_ADDR_DRAW_COLOUR;
    localparam logic [`LCDDR_ADDR_W-1:0] A_RECT = `LCDDR_ADDR_RECT_FILL_LAUNCH;
    localparam logic [`LCDDR_ADDR_W-1:0] A_LINE = `LCDDR_ADDR_LINE_DRAW_LAUNCH;
    localparam logic [`LCDDR_ADDR_W-1:0] A_COL = `LCDDR_ADDR_VIEW_ORIGIN_COL;
    localparam logic [`LCDDR_ADDR_W-1:0] A_ROW = `LCDDR_ADDR_VIEW_ORIGIN_ROW;
    localparam logic [`LCDDR_ADDR_W-1:0] A_AREA = `LCDDR_ADDR_AREA_SELECT;
    localparam logic [`LCDDR_ADDR_W-1:0] A_KEY = `LCDDR_ADDR_TRANSPARENCY_KEY;
    localparam logic [`LCDDR_ADDR_W-1:0] A_TON = `LCDDR_ADDR_TRANSPARENCY_ON;

    // Address decode works on 16-bit words; bit 0 is ignored, the byte enables pick the lane
    wire logic [`LCDDR_ADDR_W-2:0] word_addr = bus_addr_i[`LCDDR_ADDR_W-1:1];

    wire logic wr_ok = bus_wr_i && (bus_be_hi_i || bus_be_lo_i);
    wire logic sel_colour = wr_ok && (word_addr == A_COLOUR[`LCDDR_ADDR_W-1:1]);
    wire logic sel_rect = wr_ok && (word_addr == A_RECT[`LCDDR_ADDR_W-1:1]);
    wire logic sel_line = wr_ok && (word_addr == A_LINE[`LCDDR_ADDR_W-1:1]);
    wire logic sel_col = wr_ok && (word_addr == A_COL[`LCDDR_ADDR_W-1:1]);
    wire logic sel_row = wr_ok && (word_addr == A_ROW[`LCDDR_ADDR_W-1:1]);
    wire logic sel_area = wr_ok && (word_addr == A_AREA[`LCDDR_ADDR_W-1:1]);
    wire logic sel_key = wr_ok && (word_addr == A_KEY[`LCDDR_ADDR_W-1:1]);
    wire logic sel_ton = wr_ok && (word_addr == A_TON[`LCDDR_ADDR_W-1:1]);

    // Byte registers sit in the even byte, which the bus carries on 15:8
    wire logic launch_data = bus_wdata_i[`LCDDR_LAUNCH_BIT + 8];

    lcddr_colour_t colour_reg;
    lcddr_colour_t key_reg;

    logic [`LCDDR_VIEW_COL_W-1:0] col_shadow;
    logic [`LCDDR_VIEW_ROW_W-1:0] row_shadow;

    logic [3:0] area_reg;
    logic [0:0] ton_reg;

    // Stored as written, all 16 bits kept, no range checking
    lcddr_wreg #(
        .W(16),
        .BYTE_REG(1'b0),
        .RESET(`LCDDR_RST_DRAW_COLOUR)
    ) u_colour (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sel_i(sel_colour),
        .be_hi_i(bus_be_hi_i),
        .be_lo_i(bus_be_lo_i),
        .data_i(bus_wdata_i),
        .value_o(colour_reg)
    );

    // Key keeps the drawing colour bit layout
    lcddr_wreg #(
        .W(16),
        .BYTE_REG(1'b0),
        .RESET(`LCDDR_RST_TRANSPARENCY_KEY)
    ) u_key (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sel_i(sel_key),
        .be_hi_i(bus_be_hi_i),
        .be_lo_i(bus_be_lo_i),
        .data_i(bus_wdata_i),
        .value_o(key_reg)
    );

    // Shadows; the view takes them at frame start
    lcddr_wreg #(
        .W(`LCDDR_VIEW_COL_W),
        .BYTE_REG(1'b0),
        .RESET(`LCDDR_RST_VIEW_ORIGIN_COL)
    ) u_col (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sel_i(sel_col),
        .be_hi_i(bus_be_hi_i),
        .be_lo_i(bus_be_lo_i),
        .data_i(bus_wdata_i),
        .value_o(col_shadow)
    );

    lcddr_wreg #(
        .W(`LCDDR_VIEW_ROW_W),
        .BYTE_REG(1'b0),
        .RESET(`LCDDR_RST_VIEW_ORIGIN_ROW)
    ) u_row (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sel_i(sel_row),
        .be_hi_i(bus_be_hi_i),
        .be_lo_i(bus_be_lo_i),
        .data_i(bus_wdata_i),
        .value_o(row_shadow)
    );

    // Area selects act at once, no frame sync
    lcddr_wreg #(
        .W(4),
        .BYTE_REG(1'b1),
        .RESET(`LCDDR_RST_AREA_SELECT)
    ) u_area (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sel_i(sel_area),
        .be_hi_i(bus_be_hi_i),
        .be_lo_i(bus_be_lo_i),
        .data_i(bus_wdata_i),
        .value_o(area_reg)
    );

    // Enable sits in the even byte like the launch bits
    lcddr_wreg #(
        .W(1),
        .BYTE_REG(1'b1),
        .RESET(`LCDDR_RST_TRANSPARENCY_ON)
    ) u_ton (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .sel_i(sel_ton),
        .be_hi_i(bus_be_hi_i),
        .be_lo_i(bus_be_lo_i),
        .data_i(bus_wdata_i),
        .value_o(ton_reg)
    );

    wire logic transparency_on_bit = ton_reg[`LCDDR_TRANSPARENCY_ON_BIT];

    assign draw_colour_o = colour_reg;
    assign shown_area_o = {area_reg[`LCDDR_SHOWN_AREA_HI], area_reg[`LCDDR_SHOWN_AREA_LO]};
    assign target_area_o = {area_reg[`LCDDR_TARGET_AREA_HI], area_reg[`LCDDR_TARGET_AREA_LO]};

    // Launch bits: writing 0 leaves a pending launch alone
    logic rect_launch_bit_q;
    logic line_launch_bit_q;
    logic rect_start_q;
    logic line_start_q;

    wire logic rect_set = sel_rect && bus_be_hi_i && launch_data;
    wire logic line_set = sel_line && bus_be_hi_i && launch_data;

    // Busy from the engine lags a start by a cycle, so no launch right after one
    wire logic can_launch = !engine_busy_i && !rect_start_q && !line_start_q;
    wire logic rect_go = rect_launch_bit_q && can_launch;
    wire logic line_go = line_launch_bit_q && can_launch && !rect_launch_bit_q;

    // A new write in the launch cycle stays pending: set wins over clear
    wire logic rect_launch_bit_d = rect_set || (rect_launch_bit_q && !rect_go);
    wire logic line_launch_bit_d = line_set || (line_launch_bit_q && !line_go);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rect_launch_bit_q <= 1'b0;
            line_launch_bit_q <= 1'b0;
            rect_start_q <= 1'b0;
            line_start_q <= 1'b0;
        end else if (clk_en_i) begin
            rect_launch_bit_q <= rect_launch_bit_d;
            line_launch_bit_q <= line_launch_bit_d;
            rect_start_q <= rect_go;
            line_start_q <= line_go;
        end
    end

    assign rect_start_o = rect_start_q;
    assign line_start_o = line_start_q;

    // Origin changes mid-frame would tear the picture, so hold until frame start
    logic [`LCDDR_VIEW_COL_W-1:0] view_col_q;
    logic [`LCDDR_VIEW_ROW_W-1:0] view_row_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            view_col_q <= `LCDDR_RST_VIEW_ORIGIN_COL;
            view_row_q <= `LCDDR_RST_VIEW_ORIGIN_ROW;
        end else if (clk_en_i && frame_start_i) begin
            view_col_q <= col_shadow;
            view_row_q <= row_shadow;
        end
    end
    assign view_col_o = view_col_q;
    assign view_row_o = view_row_q;

    // Colour field split by colour mode
    // Fields lag the register by one cycle
    wire logic full_colour = (colour_mode_i == LCDDR_MODE_65536);

    wire logic [4:0] red_d = full_colour ? colour_reg[`LCDDR_RED_HI:`LCDDR_RED_LO] : 5'h00;
    wire logic [5:0] green_d = full_colour ? colour_reg[`LCDDR_GREEN_HI:`LCDDR_GREEN_LO] : 6'h00;
    wire logic [4:0] blue_d = full_colour ? colour_reg[`LCDDR_BLUE_HI:`LCDDR_BLUE_LO] : 5'h00;
    wire logic [1:0] pal_mode_d = full_colour ? 2'h0 : colour_reg[`LCDDR_PAL_MODE_HI:`LCDDR_PAL_MODE_LO];
    wire logic [5:0] pal_index_d = full_colour ? 6'h00 : colour_reg[`LCDDR_PAL_INDEX_HI:`LCDDR_PAL_INDEX_LO];

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            red_field_o <= 5'h00;
            green_field_o <= 6'h00;
            blue_field_o <= 5'h00;
            palette_mode_field_o <= 2'h0;
            palette_index_field_o <= 6'h00;
        end else if (clk_en_i) begin
            red_field_o <= red_d;
            green_field_o <= green_d;
            blue_field_o <= blue_d;
            palette_mode_field_o <= pal_mode_d;
            palette_index_field_o <= pal_index_d;
        end
    end

    // Transparency filter on the image pixel stream; one cycle of latency
    wire logic key_match = (img_pix_i == key_reg);
    wire logic pix_skip = img_xfer_i && transparency_on_bit && key_match;
    wire logic pix_we_d = img_pix_valid_i && !pix_skip;

    logic img_pix_we_q;
    lcddr_colour_t img_pix_q;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            img_pix_we_q <= 1'b0;
            img_pix_q <= 16'h0000;
        end else if (clk_en_i) begin
            img_pix_we_q <= pix_we_d;
            img_pix_q <= img_pix_i;
        end
    end
    assign img_pix_we_o = img_pix_we_q;
    assign img_pix_o = img_pix_q;

    // Engine done marks the last pixel committed
    wire logic op_done = rect_done_i || line_done_i;

    // A retrigger restarts the full pulse width
    lcddr_pulse_gen #(
        .CYCLES(DONE_CYCLES),
        .CW(DONE_CW)
    ) u_done (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .trig_i(op_done),
        .pulse_n_o(done_pulse_out_n_o)
    );

endmodule // lcddr_ctrl_regs

// ===== logic/lcddr_defines.svh
/*
  Constants of the drawing/display control register bank: byte addresses,
  field positions, reset values and the completion pulse timing.
  Assumes a 23-bit byte address from the host and a 200 MHz block clock.
*/
`ifndef LCDDR_DEFINES_SVH
`define LCDDR_DEFINES_SVH

`define LCDDR_ADDR_W 23
`define LCDDR_ADDR_DRAW_COLOUR 23'h7FFFD8
`define LCDDR_ADDR_RECT_FILL_LAUNCH 23'h7FFFDA
`define LCDDR_ADDR_LINE_DRAW_LAUNCH 23'h7FFFDC
`define LCDDR_ADDR_VIEW_ORIGIN_COL 23'h7FFFDE
`define LCDDR_ADDR_VIEW_ORIGIN_ROW 23'h7FFFE0
`define LCDDR_ADDR_AREA_SELECT 23'h7FFFE2
`define LCDDR_ADDR_TRANSPARENCY_KEY 23'h7FFFE4
`define LCDDR_ADDR_TRANSPARENCY_ON 23'h7FFFE6

`define LCDDR_RST_DRAW_COLOUR 16'h0000
`define LCDDR_RST_VIEW_ORIGIN_COL 11'h000
`define LCDDR_RST_VIEW_ORIGIN_ROW 10'h000
`define LCDDR_RST_AREA_SELECT 4'h0
`define LCDDR_RST_TRANSPARENCY_KEY 16'h0000
`define LCDDR_RST_TRANSPARENCY_ON 1'h0

`define LCDDR_VIEW_COL_W 11
`define LCDDR_VIEW_ROW_W 10
`define LCDDR_LAUNCH_BIT 0
`define LCDDR_TRANSPARENCY_ON_BIT 0
`define LCDDR_SHOWN_AREA_HI 3
`define LCDDR_SHOWN_AREA_LO 2
`define LCDDR_TARGET_AREA_HI 1
`define LCDDR_TARGET_AREA_LO 0
`define LCDDR_RED_HI 15
`define LCDDR_RED_LO 11
`define LCDDR_GREEN_HI 10
`define LCDDR_GREEN_LO 5
`define LCDDR_BLUE_HI 4
`define LCDDR_BLUE_LO 0
`define LCDDR_PAL_MODE_HI 7
`define LCDDR_PAL_MODE_LO 6
`define LCDDR_PAL_INDEX_HI 5
`define LCDDR_PAL_INDEX_LO 0

`define LCDDR_CLK_MHZ 200
`define LCDDR_DONE_PULSE_NS 1000
`define LCDDR_DONE_PULSE_CYC ((`LCDDR_DONE_PULSE_NS * `LCDDR_CLK_MHZ) / 1000)

`endif

// ===== logic/lcddr_pkg.sv
/*
  Types shared by the drawing/display control register bank.
  Assumes nothing beyond the constants header.
*/
package lcddr_pkg;

    typedef enum logic [1:0] {
        LCDDR_MODE_64,
        LCDDR_MODE_4096,
        LCDDR_MODE_65536
    } lcddr_colour_mode_e;

    typedef logic [15:0] lcddr_colour_t;
    typedef logic [1:0] lcddr_area_t;

endpackage

// ===== logic/lcddr_pulse_gen.sv
/*
  Active-low one-shot of a fixed number of cycles.
  Assumes trig_i is a clean one-cycle event; a new trigger restarts the pulse.
*/
`timescale 1ns/100ps
module lcddr_pulse_gen #(
    parameter int unsigned CYCLES = 200,
    parameter int unsigned CW = 8
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic trig_i,
    output logic pulse_n_o
);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;
    wire logic cnt_zero = (cnt_q == '0);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
            pulse_n_o <= 1'b1;
        end else if (clk_en_i) begin
            if (trig_i) begin
                cnt_q <= LOAD;
                pulse_n_o <= 1'b0;
            end else if (!cnt_zero) begin
                cnt_q <= cnt_q - 1'b1;
            end else begin
                pulse_n_o <= 1'b1;
            end
        end
    end
endmodule // lcddr_pulse_gen

// ===== logic/lcddr_wreg.sv
/*
  Write-only register with per-byte-lane update.
  Assumes the even-address byte sits on data bits 15:8 and the odd one on 7:0;
  a byte register lives in the even byte.
*/
`timescale 1ns/100ps
module lcddr_wreg #(
    parameter int unsigned W = 16,
    parameter bit BYTE_REG = 1'b0,
    parameter logic [W-1:0] RESET = '0
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic sel_i,
    input wire logic be_hi_i,
    input wire logic be_lo_i,
    input wire logic [15:0] data_i,
    output logic [W-1:0] value_o
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            wire logic lane_en;
            wire logic lane_bit;
            if (BYTE_REG) begin : g_byte
                assign lane_en = be_hi_i;
                assign lane_bit = data_i[i+8];
            end else if (i >= 8) begin : g_hi
                assign lane_en = be_hi_i;
                assign lane_bit = data_i[i];
            end else begin : g_lo
                assign lane_en = be_lo_i;
                assign lane_bit = data_i[i];
            end
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    value_o[i] <= RESET[i];
                end else if (clk_en_i && sel_i && lane_en) begin
                    value_o[i] <= lane_bit;
                end
            end
        end
    endgenerate
endmodule // lcddr_wreg

// ===== testbench/lcddr_ctrl_regs_asserts.sv
/*
  Port-level assertions of the control register bank.
  Assumes it is bound into lcddr_ctrl_regs and shares DONE_CYCLES.
*/
`timescale 1ns/100ps
`include "lcddr_defines.svh"
module lcddr_ctrl_regs_asserts #(
    parameter int unsigned DONE_CYCLES = 200
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic [`LCDDR_ADDR_W-1:0] bus_addr_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_be_hi_i,
    input wire logic bus_be_lo_i,
    input wire logic engine_busy_i,
    input wire logic rect_done_i,
    input wire logic line_done_i,
    input wire logic frame_start_i,
    input wire logic img_xfer_i,
    input wire logic img_pix_valid_i,
    input wire lcddr_pkg::lcddr_colour_t img_pix_i,
    input wire lcddr_pkg::lcddr_colour_t draw_colour_o,
    input wire logic rect_start_o,
    input wire logic line_start_o,
    input wire logic [`LCDDR_VIEW_COL_W-1:0] view_col_o,
    input wire logic [`LCDDR_VIEW_ROW_W-1:0] view_row_o,
    input wire lcddr_pkg::lcddr_area_t shown_area_o,
    input wire lcddr_pkg::lcddr_area_t target_area_o,
    input wire logic img_pix_we_o,
    input wire lcddr_pkg::lcddr_colour_t img_pix_o,
    input wire logic done_pulse_out_n_o
);
    import lcddr_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic wr_ok = clk_en_i && bus_wr_i;
    wire logic at_col = (bus_addr_i | 23'h000001) == (`LCDDR_ADDR_DRAW_COLOUR | 23'h000001);
    wire logic at_area = (bus_addr_i | 23'h000001) == (`LCDDR_ADDR_AREA_SELECT | 23'h000001);
    wire logic trig = (rect_done_i || line_done_i) && clk_en_i;
    logic [15:0] low_cnt_q;
    // A retrigger starts the count over, as the pulse itself does
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt_q <= 16'h0000;
        end else if (trig || done_pulse_out_n_o) begin
            low_cnt_q <= 16'h0000;
        end else if (clk_en_i) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end
    property p_done_fall; trig |=> !done_pulse_out_n_o; endproperty
    a_done_fall: assert property (p_done_fall) else $error("done pulse late");
    property p_done_len; $rose(done_pulse_out_n_o) |-> low_cnt_q == DONE_CYCLES; endproperty
    a_done_len: assert property (p_done_len) else $error("done pulse length");
    property p_area; wr_ok && at_area && bus_be_hi_i |=> {shown_area_o, target_area_o} == $past(bus_wdata_i[11:8]);
    endproperty
    a_area: assert property (p_area) else $error("area select");
    property p_col_hi; wr_ok && at_col && bus_be_hi_i && !bus_be_lo_i |=>
        draw_colour_o == {$past(bus_wdata_i[15:8]), $past(draw_colour_o[7:0])}; endproperty
    a_col_hi: assert property (p_col_hi) else $error("colour byte lane");
    property p_origin; !frame_start_i |=> $stable(view_col_o) && $stable(view_row_o); endproperty
    a_origin: assert property (p_origin) else $error("origin mid frame");
    property p_start_idle; rect_start_o || line_start_o |-> !$past(engine_busy_i); endproperty
    a_start_idle: assert property (p_start_idle) else $error("start while busy");
    property p_start_one; rect_start_o || line_start_o |-> (rect_start_o ^ line_start_o) ##1
        !(rect_start_o || line_start_o); endproperty
    a_start_one: assert property (p_start_one) else $error("start not single");
    property p_pix_pass; img_pix_valid_i && clk_en_i && !img_xfer_i |=>
        img_pix_we_o && img_pix_o == $past(img_pix_i); endproperty
    a_pix_pass: assert property (p_pix_pass) else $error("pixel dropped");
endmodule // lcddr_ctrl_regs_asserts
bind lcddr_ctrl_regs lcddr_ctrl_regs_asserts #(.DONE_CYCLES(DONE_CYCLES)) u_lcddr_ctrl_regs_asserts (
    .sys_clk_i, .rstn_i, .clk_en_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_be_hi_i, .bus_be_lo_i,
    .engine_busy_i, .rect_done_i, .line_done_i, .frame_start_i, .img_xfer_i, .img_pix_valid_i, .img_pix_i,
    .draw_colour_o, .rect_start_o, .line_start_o, .view_col_o, .view_row_o, .shown_area_o, .target_area_o,
    .img_pix_we_o, .img_pix_o, .done_pulse_out_n_o);

// ===== testbench/lcddr_ctrl_regs_tb.sv
/*
  Self-checking bench of the control register bank with an engine model.
  Assumes the checker is bound and DONE_CYCLES is shortened to 4.
*/
`timescale 1ns/100ps
`include "lcddr_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module lcddr_ctrl_regs_tb;
    import lcddr_pkg::*;
    localparam int unsigned DC = 4;
    logic sys_clk_i = 0, rstn_i = 0, clk_en_i = 1, bus_wr_i = 0, bus_be_hi_i = 0, bus_be_lo_i = 0;
    logic frame_start_i = 0, img_xfer_i = 0, img_pix_valid_i = 0, done_d = 1;
    logic [22:0] bus_addr_i = '0;
    lcddr_colour_t bus_wdata_i = '0, img_pix_i = '0, draw_colour_o, img_pix_o;
    lcddr_colour_mode_e colour_mode_i = LCDDR_MODE_65536;
    logic engine_busy_i, rect_done_i, line_done_i, rect_start_o, line_start_o, img_pix_we_o, done_pulse_out_n_o;
    logic [4:0] red_field_o, blue_field_o;
    logic [5:0] green_field_o, palette_index_field_o;
    logic [1:0] palette_mode_field_o, shown_area_o, target_area_o;
    logic [10:0] view_col_o;
    logic [9:0] view_row_o;
    logic [7:0] lat = 8'h02;
    logic [19:0] q[$], exp_v;
    logic [31:0] rng = 32'h00016ED2;
    int failures = 0, checks_done = 0;
    lcddr_ctrl_regs #(.DONE_CYCLES(DC), .DONE_CW(8)) u_lcddr_ctrl_regs (.sys_clk_i, .rstn_i, .clk_en_i,
        .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_be_hi_i, .bus_be_lo_i, .colour_mode_i, .engine_busy_i,
        .rect_done_i, .line_done_i, .frame_start_i, .img_xfer_i, .img_pix_valid_i, .img_pix_i, .draw_colour_o,
        .red_field_o, .green_field_o, .blue_field_o, .palette_mode_field_o, .palette_index_field_o,
        .rect_start_o, .line_start_o, .view_col_o, .view_row_o, .shown_area_o, .target_area_o, .img_pix_we_o,
        .img_pix_o, .done_pulse_out_n_o);
    lcddr_engine_model u_lcddr_engine_model (.sys_clk_i, .rect_start_i(rect_start_o),
        .line_start_i(line_start_o), .lat_i(lat), .busy_o(engine_busy_i), .rect_done_o(rect_done_i),
        .line_done_o(line_done_i));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    function automatic logic [15:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction
    task automatic end_of_test();
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [22:0] a, input logic [15:0] d, input logic hi, input logic lo);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_be_hi_i <= hi;
        bus_be_lo_i <= lo;
        bus_wr_i <= 1'b1;
        @(posedge sys_clk_i) bus_wr_i <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task automatic px(input logic [15:0] v, input logic skip);
        if (!skip) q.push_back({4'h8, v});
        @(posedge sys_clk_i);
        img_pix_valid_i <= 1'b1;
        img_pix_i <= v;
    endtask
    task automatic launch(input logic [22:0] a, input logic [3:0] kind);
        q.push_back({kind, 16'h0000});
        q.push_back({4'h4, 16'h0000});
        wr(a, 16'h0100, 1'b1, 1'b0);
    endtask
    task automatic drain();
        int n;
        n = 0;
        @(posedge sys_clk_i) img_pix_valid_i <= 1'b0;
        while (q.size() != 0 && n < 3000) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (q.size() != 0) begin
            failures++;
            end_of_test();
        end
        repeat (DC + 8) @(posedge sys_clk_i);
    endtask
    // Every event seen at the outputs must be the oldest one noted
    always @(negedge sys_clk_i) begin
        if (rect_start_o || line_start_o) begin
            exp_v = (q.size() != 0) ? q.pop_front() : 'x;
            `CHK({2'b00, rect_start_o, line_start_o, 16'h0000}, exp_v)
        end
        if (!done_pulse_out_n_o && done_d) begin
            exp_v = (q.size() != 0) ? q.pop_front() : 'x;
            `CHK(20'h40000, exp_v)
        end
        if (img_pix_we_o) begin
            exp_v = (q.size() != 0) ? q.pop_front() : 'x;
            `CHK({4'h8, img_pix_o}, exp_v)
        end
        done_d = done_pulse_out_n_o;
    end
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        failures++;
        end_of_test();
    end
    initial begin
        logic [15:0] d;
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        wr(`LCDDR_ADDR_DRAW_COLOUR, 16'hAB55, 1'b1, 1'b0);
        wr(`LCDDR_ADDR_DRAW_COLOUR | 23'h000001, 16'h12CD, 1'b0, 1'b1);
        settle();
        `CHK(draw_colour_o, 16'hABCD)
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk_i) colour_mode_i <= lcddr_colour_mode_e'(m);
            d = rnd();
            wr(`LCDDR_ADDR_DRAW_COLOUR, d, 1'b1, 1'b1);
            settle();
            `CHK(draw_colour_o, d)
            `CHK({red_field_o, green_field_o, blue_field_o, palette_mode_field_o, palette_index_field_o},
                (m == 2) ? {d, 8'h00} : {16'h0000, d[7:0]})
        end
        // A frozen clock enable must swallow the write
        @(posedge sys_clk_i) clk_en_i <= 1'b0;
        wr(`LCDDR_ADDR_DRAW_COLOUR, ~d, 1'b1, 1'b1);
        @(posedge sys_clk_i) clk_en_i <= 1'b1;
        settle();
        `CHK(draw_colour_o, d)
        for (int a = 0; a < 16; a++) begin
            wr(`LCDDR_ADDR_AREA_SELECT, {4'hA, a[3:0], 8'hFF}, 1'b1, 1'b0);
            settle();
            `CHK({shown_area_o, target_area_o}, a[3:0])
        end
        wr(`LCDDR_ADDR_AREA_SELECT, 16'h0000, 1'b0, 1'b1);
        wr(23'h7FFFE8, 16'h0000, 1'b1, 1'b1);
        settle();
        `CHK({shown_area_o, target_area_o, draw_colour_o}, {4'hF, d})
        wr(`LCDDR_ADDR_VIEW_ORIGIN_COL, 16'h07FF, 1'b1, 1'b1);
        wr(`LCDDR_ADDR_VIEW_ORIGIN_ROW, 16'h03FF, 1'b1, 1'b1);
        settle();
        `CHK({view_col_o, view_row_o}, 21'h000000)
        @(posedge sys_clk_i) frame_start_i <= 1'b1;
        @(posedge sys_clk_i) frame_start_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK({view_col_o, view_row_o}, {11'h7FF, 10'h3FF})
        launch(`LCDDR_ADDR_RECT_FILL_LAUNCH, 4'h2);
        drain();
        launch(`LCDDR_ADDR_LINE_DRAW_LAUNCH, 4'h1);
        wr(`LCDDR_ADDR_RECT_FILL_LAUNCH, 16'h0000, 1'b1, 1'b0);
        drain();
        // Slow engine: a line and a fill queue up behind a running fill
        lat <= 8'h28;
        launch(`LCDDR_ADDR_RECT_FILL_LAUNCH, 4'h2);
        wr(`LCDDR_ADDR_LINE_DRAW_LAUNCH, 16'h0100, 1'b1, 1'b0);
        launch(`LCDDR_ADDR_RECT_FILL_LAUNCH, 4'h2);
        q.push_back(20'h10000);
        q.push_back(20'h40000);
        drain();
        wr(`LCDDR_ADDR_TRANSPARENCY_ON, 16'h0100, 1'b1, 1'b0);
        @(posedge sys_clk_i) img_xfer_i <= 1'b1;
        px(16'h0000, 1'b1);
        px(16'h0001, 1'b0);
        drain();
        wr(`LCDDR_ADDR_TRANSPARENCY_KEY, 16'h1234, 1'b1, 1'b1);
        px(16'h1234, 1'b1);
        px(16'h1235, 1'b0);
        px(16'h9234, 1'b0);
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            px(d, d == 16'h1234);
        end
        drain();
        wr(`LCDDR_ADDR_TRANSPARENCY_ON, 16'h0000, 1'b1, 1'b0);
        px(16'h1234, 1'b0);
        drain();
        wr(`LCDDR_ADDR_TRANSPARENCY_ON, 16'h0100, 1'b1, 1'b0);
        @(posedge sys_clk_i) img_xfer_i <= 1'b0;
        px(16'h1234, 1'b0);
        drain();
        end_of_test();
    end
endmodule // lcddr_ctrl_regs_tb

// ===== testbench/lcddr_engine_model.sv
/*
  Behavioural drawing engine that answers fill and line start pulses.
  Assumes one-cycle start pulses; lat_i sets how long each job runs.
*/
`timescale 1ns/100ps
module lcddr_engine_model (
    input wire logic sys_clk_i,
    input wire logic rect_start_i,
    input wire logic line_start_i,
    input wire logic [7:0] lat_i,
    output logic busy_o,
    output logic rect_done_o,
    output logic line_done_o
);
    logic kind;
    initial begin
        busy_o = 1'b0;
        rect_done_o = 1'b0;
        line_done_o = 1'b0;
        forever begin
            // Sample mid-cycle so the start flop has settled
            @(negedge sys_clk_i);
            if (rect_start_i || line_start_i) begin
                kind = rect_start_i;
                @(posedge sys_clk_i) busy_o <= 1'b1;
                repeat (lat_i) @(posedge sys_clk_i);
                rect_done_o <= kind;
                line_done_o <= !kind;
                @(posedge sys_clk_i);
                rect_done_o <= 1'b0;
                line_done_o <= 1'b0;
                // Busy outlives done so a queued launch follows the pulse
                @(posedge sys_clk_i) busy_o <= 1'b0;
            end
        end
    end
endmodule // lcddr_engine_model
